/* bfci_pkg.sv */
package bfci_pkg;

  localparam int CLK_NS     = 8;
  localparam int T_RAND_NS  = 65;
  localparam int T_PAGE_NS  = 25;
  localparam int T_WP_NS    = 35;
  localparam int T_GAP_NS   = 20;
  localparam int SYNC_CYC   = 2;

  // least times round up, never below one cycle
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RAND_CYC   = ns2cyc(T_RAND_NS) + SYNC_CYC;
  localparam int PAGE_CYC   = ns2cyc(T_PAGE_NS) + SYNC_CYC;
  localparam int WP_CYC     = ns2cyc(T_WP_NS);
  localparam int GAP_CYC    = ns2cyc(T_GAP_NS);

  localparam int ADDR_W     = 23;
  localparam int DATA_W     = 16;
  localparam int PAGE_WORDS = 8;
  localparam int CNT_W      = 8;

  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_ADDR   = 12'h004;
  localparam logic [11:0] REG_WDATA  = 12'h008;
  localparam logic [11:0] REG_CMD    = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [11:0] REG_RDATA  = 12'h014;
  localparam logic [11:0] REG_PAGE   = 12'h020;
  localparam logic [11:0] PAGE_MASK  = 12'hfe0;

  localparam int CTRL_STANDBY = 0;
  localparam int ST_BUSY      = 0;
  localparam int ST_REFUSED   = 1;
  localparam int ST_TIMEOUT   = 2;
  localparam int ST_DONE      = 3;
  localparam logic CTRL_RESET = 1'b1;

  localparam logic [3:0] OP_READ      = 4'h1;
  localparam logic [3:0] OP_PAGE      = 4'h2;
  localparam logic [3:0] OP_PROG      = 4'h3;
  localparam logic [3:0] OP_BYP_ENTER = 4'h4;
  localparam logic [3:0] OP_BYP_PROG  = 4'h5;
  localparam logic [3:0] OP_BYP_EXIT  = 4'h6;
  localparam logic [3:0] OP_ERASE     = 4'h7;
  localparam logic [3:0] OP_SUSPEND   = 4'h8;
  localparam logic [3:0] OP_RESUME    = 4'h9;
  localparam logic [3:0] OP_OTP_ENTER = 4'ha;
  localparam logic [3:0] OP_OTP_EXIT  = 4'hb;
  localparam logic [3:0] OP_RESET     = 4'hc;
  localparam logic [3:0] OP_POLL      = 4'hd;

  localparam logic [10:0] UNLOCK_A1 = 11'h555;
  localparam logic [10:0] UNLOCK_A2 = 11'h2aa;
  localparam logic [15:0] D_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] D_UNLOCK2 = 16'h0055;
  localparam logic [15:0] D_PROG    = 16'h00a0;
  localparam logic [15:0] D_BYPASS  = 16'h0020;
  localparam logic [15:0] D_BYP_X1  = 16'h0090;
  localparam logic [15:0] D_ZERO    = 16'h0000;
  localparam logic [15:0] D_ERASE   = 16'h0080;
  localparam logic [15:0] D_SECTOR  = 16'h0030;
  localparam logic [15:0] D_SUSPEND = 16'h00b0;
  localparam logic [15:0] D_OTP     = 16'h0088;
  localparam logic [15:0] D_RESET   = 16'h00f0;

  typedef struct packed {
    logic              wr;
    logic              keep;
    logic              fast;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bfci_cyc_t;

  typedef struct packed {
    logic              sel_n;
    logic              oe_n;
    logic              we_n;
    logic              dq_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
  } bfci_pins_t;

endpackage

/* bfci_page_buf.sv */
`timescale 1ns/100ps
module bfci_page_buf
  import bfci_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = PAGE_WORDS
) (
  input  wire logic                     hclk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2) begin : g_chk
    $error("page buffer needs at least two words");
  end

  // no reset: contents are only meaningful after a page read fills them
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule

/* bfci_cycle.sv */
`timescale 1ns/100ps
module bfci_cycle
  import bfci_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              start,
  input  wire bfci_cyc_t         req,
  input  wire logic              standby,
  input  wire logic [DATA_W-1:0] dq_sync,
  output logic                   done,
  output logic      [DATA_W-1:0] rdata,
  output bfci_pins_t             pins
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} bfci_est_t;

  bfci_est_t         st, next_st;
  bfci_pins_t        next_pins;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic              wr, next_wr, keep, next_keep, held, next_held;
  logic              next_done;
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_st    = st;
    next_pins  = pins;
    next_cnt   = cnt;
    next_wr    = wr;
    next_keep  = keep;
    next_held  = held;
    next_done  = 1'b0;
    next_rdata = rdata;
    case (st)
      E_IDLE: begin
        if (start) begin
          next_wr          = req.wr;
          next_keep        = req.keep;
          next_held        = 1'b0;
          next_pins.addr   = req.addr;
          next_pins.dq_out = req.data;
          next_pins.dq_oe  = req.wr;
          next_pins.sel_n  = 1'b0;
          next_pins.oe_n   = req.wr;
          next_pins.we_n   = 1'b1;
          if (req.wr) begin
            next_st  = E_SETUP;
            next_cnt = CNT_W'(WP_CYC);
          end else begin
            next_st  = E_STROBE;
            next_cnt = req.fast ? CNT_W'(PAGE_CYC) : CNT_W'(RAND_CYC);
          end
        end else if (!held) begin
          // select high is standby; select low with stable address lets the part doze
          next_pins.sel_n = standby;
          next_pins.oe_n  = 1'b1;
          next_pins.we_n  = 1'b1;
          next_pins.dq_oe = 1'b0;
        end
      end
      E_SETUP: begin
        next_pins.we_n = 1'b0;
        next_st        = E_STROBE;
      end
      E_STROBE: begin
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1)) begin
          if (wr) begin
            next_pins.we_n = 1'b1;
            next_cnt       = CNT_W'(GAP_CYC);
            next_st        = E_HOLD;
          end else begin
            next_rdata = dq_sync;
            if (keep) begin
              next_held = 1'b1;
              next_done = 1'b1;
              next_st   = E_IDLE;
            end else begin
              next_pins.oe_n = 1'b1;
              next_cnt       = CNT_W'(GAP_CYC);
              next_st        = E_HOLD;
            end
          end
        end
      end
      E_HOLD: begin
        next_cnt = cnt - CNT_W'(1);
        if (cnt == CNT_W'(1)) begin
          next_pins.dq_oe = 1'b0;
          next_pins.sel_n = standby;
          next_done       = 1'b1;
          next_st         = E_IDLE;
        end
      end
      default: next_st = E_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st    <= E_IDLE;
      pins  <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, addr: '0, dq_out: '0};
      cnt   <= '0;
      wr    <= 1'b0;
      keep  <= 1'b0;
      held  <= 1'b0;
      done  <= 1'b0;
      rdata <= '0;
    end else begin
      st    <= next_st;
      pins  <= next_pins;
      cnt   <= next_cnt;
      wr    <= next_wr;
      keep  <= next_keep;
      held  <= next_held;
      done  <= next_done;
      rdata <= next_rdata;
    end
  end

endmodule

/* bfci_host.sv */
`timescale 1ns/100ps
// Overview of operation
// - commands go out as ordinary write strobes; program, erase, bypass entry and one-time entry and exit open with the standard unlock cycles
// - program takes four write cycles, bypass program only two
// - erase starts only from the full six-cycle erase sequence
// - one-time region needs its entry sequence before use and exit after
// - the host can put the part into standby
// - host drives separate select, write strobe and output enable
module bfci_host
  import bfci_pkg::*;
#(
  parameter int POLL_LIMIT = 65536
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic      [31:0]       hrdata,
  output logic                   hresp,
  output logic      [ADDR_W-1:0] flash_addr,
  output logic                   flash_select_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic      [DATA_W-1:0] word_data_lines_out,
  output logic                   word_data_lines_oe,
  input  wire logic [DATA_W-1:0] word_data_lines_in
);

  if (POLL_LIMIT < 2 || POLL_LIMIT > 32'h00ff_ffff) begin : g_chk
    $error("poll limit out of range");
  end

  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLLW} bfci_st_t;

  // command sequences: unlock cycles carry the target's upper bits so they land in its bank
  function automatic bfci_cyc_t seq_step(input logic [3:0] op, input logic [2:0] i,
                                         input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bfci_cyc_t c;
    logic [ADDR_W-1:0] u1, u2;
    u1 = {a[ADDR_W-1:11], UNLOCK_A1};
    u2 = {a[ADDR_W-1:11], UNLOCK_A2};
    c  = '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: u1, data: D_UNLOCK1};
    if (i[0] ^ (op == OP_ERASE && i > 3'd2)) begin
      c.addr = u2;
      c.data = D_UNLOCK2;
    end
    case (op)
      OP_READ: c = '{wr: 1'b0, keep: 1'b0, fast: 1'b0, addr: a, data: D_ZERO};
      OP_PAGE: c = '{wr: 1'b0, keep: (i != 3'd7), fast: (i != 3'd0), addr: {a[ADDR_W-1:3], i}, data: D_ZERO};
      OP_PROG: begin
        if (i == 3'd2) c.data = D_PROG;
        if (i == 3'd3) c = '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: a, data: d};
      end
      OP_BYP_ENTER: if (i == 3'd2) c.data = D_BYPASS;
      OP_BYP_PROG: c = (i == 3'd0) ? '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: a, data: D_PROG}
                                   : '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: a, data: d};
      OP_BYP_EXIT: c = '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: a, data: (i == 3'd0) ? D_BYP_X1 : D_ZERO};
      OP_ERASE: begin
        if (i == 3'd2) c.data = D_ERASE;
        if (i == 3'd5) c = '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: a, data: D_SECTOR};
      end
      OP_SUSPEND: c = '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: a, data: D_SUSPEND};
      OP_RESUME: c = '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: a, data: D_SECTOR};
      OP_OTP_ENTER: if (i == 3'd2) c.data = D_OTP;
      OP_OTP_EXIT: begin
        if (i == 3'd2) c.data = D_BYP_X1;
        if (i == 3'd3) c.data = D_ZERO;
      end
      OP_RESET: c = '{wr: 1'b1, keep: 1'b0, fast: 1'b0, addr: a, data: D_RESET};
      default: c = '{wr: 1'b0, keep: 1'b0, fast: 1'b0, addr: a, data: D_ZERO};
    endcase
    return c;
  endfunction

  function automatic logic [2:0] seq_last(input logic [3:0] op);
    case (op)
      OP_PAGE:                     seq_last = 3'd7;
      OP_PROG, OP_OTP_EXIT:        seq_last = 3'd3;
      OP_BYP_PROG, OP_BYP_EXIT:    seq_last = 3'd1;
      OP_BYP_ENTER, OP_OTP_ENTER:  seq_last = 3'd2;
      OP_ERASE:                    seq_last = 3'd5;
      default:                     seq_last = 3'd0;
    endcase
  endfunction

  function automatic logic op_valid(input logic [3:0] op);
    op_valid = (op >= OP_READ) && (op <= OP_POLL);
  endfunction

  // bus slave state
  logic              rd_pend, next_rd_pend, wr_pend, next_wr_pend;
  logic [11:0]       aoff, next_aoff;
  logic [31:0]       next_hrdata;
  logic              standby, next_standby;
  logic [ADDR_W-1:0] taddr, next_taddr;
  logic [DATA_W-1:0] wdata, next_wdata, rword, next_rword;
  logic [3:0]        op, next_op;
  logic              refused, next_refused, tmo, next_tmo, fin, next_fin;
  // sequencer state
  bfci_st_t          st, next_st;
  logic [2:0]        step, next_step;
  logic [23:0]       pcnt, next_pcnt;
  logic              have_prev, next_have_prev;
  logic [DATA_W-1:0] prev, next_prev;
  // pins and engine
  logic [DATA_W-1:0] dq_meta, dq_sync;
  bfci_pins_t        pins;
  bfci_cyc_t         req;
  logic              cyc_start, cyc_done;
  logic [DATA_W-1:0] cyc_rdata, buf_rdata;
  logic              busy, cmd_wr, polled_done;

  assign busy     = (st != S_IDLE);
  assign cmd_wr   = wr_pend && (aoff == REG_CMD);
  assign hreadyout = !rd_pend;
  assign hresp    = 1'b0;

  assign flash_addr          = pins.addr;
  assign flash_select_n      = pins.sel_n;
  assign flash_we_n          = pins.we_n;
  assign flash_oe_n          = pins.oe_n;
  assign word_data_lines_out = pins.dq_out;
  assign word_data_lines_oe  = pins.dq_oe;

  assign cyc_start = (st == S_ISSUE) || (st == S_POLL);
  assign req = (st == S_POLL) ? '{wr: 1'b0, keep: 1'b0, fast: 1'b0, addr: taddr, data: D_ZERO}
                              : seq_step(op, step, taddr, wdata);
  // toggle bit steady and, for a program, poll bit equal to the written bit
  assign polled_done = have_prev && (cyc_rdata[6] == prev[6]) &&
                       ((op == OP_POLL) || (cyc_rdata[7] == wdata[7]));

  always_comb begin
    next_rd_pend = hsel && hready && htrans[1] && !hwrite;
    next_wr_pend = hsel && hready && htrans[1] && hwrite;
    next_aoff    = (hsel && hready && htrans[1]) ? {haddr[11:2], 2'b00} : aoff;
    next_hrdata  = hrdata;
    next_standby = standby;
    next_taddr   = taddr;
    next_wdata   = wdata;
    next_refused = refused;
    next_tmo     = tmo;
    next_fin     = fin;
    if (rd_pend) begin
      next_hrdata = 32'h0000_0000;
      if (aoff == REG_CTRL) begin
        next_hrdata[CTRL_STANDBY] = standby;
      end else if (aoff == REG_ADDR) begin
        next_hrdata[ADDR_W-1:0] = taddr;
      end else if (aoff == REG_WDATA) begin
        next_hrdata[DATA_W-1:0] = wdata;
      end else if (aoff == REG_CMD) begin
        next_hrdata[3:0] = op;
      end else if (aoff == REG_STATUS) begin
        next_hrdata[3:0] = {fin, tmo, refused, busy};
      end else if (aoff == REG_RDATA) begin
        next_hrdata[DATA_W-1:0] = rword;
      end else if ((aoff & PAGE_MASK) == REG_PAGE) begin
        next_hrdata[DATA_W-1:0] = buf_rdata;
      end
    end
    if (wr_pend) begin
      if (aoff == REG_CTRL) begin
        next_standby = hwdata[CTRL_STANDBY];
      end else if (aoff == REG_ADDR && !busy) begin
        next_taddr = hwdata[ADDR_W-1:0];
      end else if (aoff == REG_WDATA && !busy) begin
        next_wdata = hwdata[DATA_W-1:0];
      end else if (aoff == REG_STATUS) begin
        next_refused = refused && !hwdata[ST_REFUSED];
        next_tmo     = tmo && !hwdata[ST_TIMEOUT];
        next_fin     = fin && !hwdata[ST_DONE];
      end
    end
    // hardware sets after the software clear, so a same-cycle event survives
    if (cmd_wr && (busy || !op_valid(hwdata[3:0]))) begin
      next_refused = 1'b1;
    end
    if (st == S_POLLW && cyc_done && !polled_done && pcnt == 24'(POLL_LIMIT - 1)) begin
      next_tmo = 1'b1;
    end
    if ((st == S_WAIT || st == S_POLLW) && cyc_done && next_st == S_IDLE) begin
      next_fin = 1'b1;
    end
  end

  always_comb begin
    next_st        = st;
    next_op        = op;
    next_step      = step;
    next_pcnt      = pcnt;
    next_have_prev = have_prev;
    next_prev      = prev;
    next_rword     = rword;
    case (st)
      S_IDLE: begin
        if (cmd_wr && op_valid(hwdata[3:0])) begin
          next_op        = hwdata[3:0];
          next_step      = 3'd0;
          next_pcnt      = '0;
          next_have_prev = 1'b0;
          next_st        = (hwdata[3:0] == OP_POLL) ? S_POLL : S_ISSUE;
        end
      end
      S_ISSUE: next_st = S_WAIT;
      S_WAIT: begin
        if (cyc_done) begin
          if (op == OP_READ) begin
            next_rword = cyc_rdata;
          end
          if (step != seq_last(op)) begin
            next_step = step + 3'd1;
            next_st   = S_ISSUE;
          end else if (op == OP_PROG || op == OP_BYP_PROG) begin
            next_st = S_POLL;
          end else begin
            // erase and resume return at once; software polls later so it may suspend
            next_st = S_IDLE;
          end
        end
      end
      S_POLL: next_st = S_POLLW;
      S_POLLW: begin
        if (cyc_done) begin
          next_prev      = cyc_rdata;
          next_rword     = cyc_rdata;
          next_have_prev = 1'b1;
          next_pcnt      = pcnt + 24'd1;
          if (polled_done || pcnt == 24'(POLL_LIMIT - 1)) begin
            next_st = S_IDLE;
          end else begin
            next_st = S_POLL;
          end
        end
      end
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      aoff    <= '0;
      hrdata  <= 32'h0000_0000;
      standby <= CTRL_RESET;
      taddr   <= '0;
      wdata   <= '0;
      refused <= 1'b0;
      tmo     <= 1'b0;
      fin     <= 1'b0;
      dq_meta <= '0;
      dq_sync <= '0;
    end else begin
      rd_pend <= next_rd_pend;
      wr_pend <= next_wr_pend;
      aoff    <= next_aoff;
      hrdata  <= next_hrdata;
      standby <= next_standby;
      taddr   <= next_taddr;
      wdata   <= next_wdata;
      refused <= next_refused;
      tmo     <= next_tmo;
      fin     <= next_fin;
      dq_meta <= word_data_lines_in;
      dq_sync <= dq_meta;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st        <= S_IDLE;
      op        <= '0;
      step      <= '0;
      pcnt      <= '0;
      have_prev <= 1'b0;
      prev      <= '0;
      rword     <= '0;
    end else begin
      st        <= next_st;
      op        <= next_op;
      step      <= next_step;
      pcnt      <= next_pcnt;
      have_prev <= next_have_prev;
      prev      <= next_prev;
      rword     <= next_rword;
    end
  end

  bfci_cycle u_cycle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (cyc_start),
    .req     (req),
    .standby (standby),
    .dq_sync (dq_sync),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .pins    (pins)
  );

  bfci_page_buf #(
    .WIDTH (DATA_W),
    .DEPTH (PAGE_WORDS)
  ) u_page (
    .hclk    (hclk),
    .wr_en   (st == S_WAIT && cyc_done && op == OP_PAGE),
    .wr_idx  (step),
    .wr_data (cyc_rdata),
    .rd_idx  (next_aoff[4:2]),  // read port is registered, so index the word one cycle early
    .rd_data (buf_rdata)
  );

endmodule

/* bfci_flash_model.sv */
`timescale 1ns/100ps
module bfci_flash_model
  import bfci_pkg::*;
#(
  parameter int PROT_SECT = 9,
  parameter int PROG_NS   = 300,
  parameter int ERASE_NS  = 1500
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              sel_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic                   dq_en,
  output logic      [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [int];
  logic [2:0]        st = 0;
  logic              byp = 0;
  logic              tog = 0;
  logic [7:0]        pd = 0;
  realtime           bt = 0;
  realtime           rem = 0;
  logic [1:0]        bb = 0;
  logic              vcc_low = 0;
  // unwritten words read as erased
  function automatic logic [15:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // eight small boot sectors at each end of the array, large sectors elsewhere
  function automatic int sect(input int a);
    return (a < 32'h0000_8000 || a >= 32'h007f_8000) ? a >> 12 : (a >> 15) + 32'h0000_0800;
  endfunction
  assign dq_en = !sel_n && !oe_n && we_n;
  // answers fast; only the bank running the operation shows status
  always #1 dq = ($realtime < bt && addr[22:21] == bb) ? {8'h00, ~pd[7], tog, 6'h00} : rd(addr);
  always @(negedge oe_n) if ($realtime < bt) tog <= !tog;
  // suspend parks the remaining erase time until resume
  always @(posedge we_n) if (!sel_n && $realtime < bt && dq_in == D_SUSPEND) begin
    rem = bt - $realtime;
    bt = 0;
  end
  // writes other than suspend while busy are dropped, and on low supply every write but that suspend is dropped too
  always @(posedge we_n) if (!sel_n && !vcc_low && $realtime >= bt) begin
    case (st)
      0: if (dq_in == D_UNLOCK1 && addr[10:0] == UNLOCK_A1) st = 1;
         else if (byp && dq_in == D_PROG) st = 3;
         else if (byp && dq_in == D_BYP_X1) st = 7;
         else if (rem > 0 && dq_in == D_SECTOR) begin
           bt = $realtime + rem;
           rem = 0;
         end
      1: st = (dq_in == D_UNLOCK2 && addr[10:0] == UNLOCK_A2) ? 3'd2 : 3'd0;
      2: begin
        byp = byp | (dq_in == D_BYPASS);
        st = (dq_in == D_PROG) ? 3'd3 : (dq_in == D_ERASE) ? 3'd4 : 3'd0;
      end
      3: begin
        if (sect(addr) != sect(PROT_SECT << 15)) begin
          mem[addr] = rd(addr) & dq_in;
          bb = addr[22:21];
          pd = dq_in[7:0];
          bt = $realtime + PROG_NS;
        end
        st = 0;
      end
      4: st = (dq_in == D_UNLOCK1) ? 3'd5 : 3'd0;
      5: st = (dq_in == D_UNLOCK2) ? 3'd6 : 3'd0;
      6: begin
        if (dq_in == D_SECTOR && sect(addr) != sect(PROT_SECT << 15)) begin
          foreach (mem[j]) if (sect(j) == sect(addr)) mem[j] = 16'hffff;
          bb = addr[22:21];
          pd = 8'h00;
          bt = $realtime + ERASE_NS;
        end
        st = 0;
      end
      default: begin
        byp = (dq_in != D_ZERO);
        st = 0;
      end
    endcase
  end
endmodule

/* bfci_host_props.sv */
`timescale 1ns/100ps
module bfci_host_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [22:0] flash_addr,
  input wire logic        flash_select_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic        word_data_lines_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_strobe;
    !flash_we_n [*5] ##1 flash_we_n;
  endsequence
  a_no_fight: assert property (!(!flash_oe_n && word_data_lines_oe))
    else $error("host drives data while output enabled");
  a_oe_we_apart: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("output and write enables low together");
  a_strobe_ctx: assert property (!flash_we_n |-> !flash_select_n && word_data_lines_oe)
    else $error("write strobe without select or data");
  a_strobe_width: assert property ($fell(flash_we_n) |-> s_strobe)
    else $error("write strobe width wrong");
  a_data_hold: assert property ($rose(flash_we_n) |-> word_data_lines_oe [*3])
    else $error("data released too early");
  a_addr_steady: assert property (!flash_we_n |-> $stable(flash_addr))
    else $error("address moved during strobe");
  a_read_hold: assert property ($fell(flash_oe_n) |-> !flash_select_n throughout (!flash_oe_n [*8]))
    else $error("read cut short");
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> s_one_wait)
    else $error("read wait state wrong");
  a_write_fast: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (!hresp)
    else $error("bus response not okay");
endmodule
bind bfci_host bfci_host_props i_bfci_host_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .flash_addr, .flash_select_n, .flash_we_n, .flash_oe_n, .word_data_lines_oe);

/* testbench.sv */
`timescale 1ns/100ps
module testbench
  import bfci_pkg::*;
;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic        hready, hoe, fs_n, fwe_n, foe_n, men;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv, sv;
  logic [22:0] fa;
  logic [15:0] hout, mq, din;
  logic [3:0]  codes [3] = '{OP_OTP_ENTER, OP_OTP_EXIT, OP_RESET};
  int          cnt [3] = '{3, 4, 1};
  int          errors = 0, samples_checked = 0, n = 0, cyc = 0;
  always #4 hclk = !hclk;
  // released lines float up through pull-ups
  assign din = hoe ? hout : men ? mq : 16'hffff;
  always @(negedge fwe_n) n++;
  always @(posedge hclk) if (++cyc == 80000) begin
    errors++;
    conclude;
  end
  bfci_host #(.POLL_LIMIT(64)) i_bfci_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp(), .flash_addr(fa), .flash_select_n(fs_n),
    .flash_we_n(fwe_n), .flash_oe_n(foe_n), .word_data_lines_out(hout), .word_data_lines_oe(hoe),
    .word_data_lines_in(din));
  bfci_flash_model i_bfci_flash_model (.addr(fa), .sel_n(fs_n), .we_n(fwe_n), .oe_n(foe_n), .dq_in(din),
    .dq_en(men), .dq(mq));
  // ready is read before the edge so the flop update cannot race the check
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic r;
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do begin @(negedge hclk); r = hready; @(posedge hclk); end while (!r);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(negedge hclk); r = hready; rv = hrdata; @(posedge hclk); end while (!r);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task op(input logic [22:0] a, input logic [15:0] d, input logic [3:0] c);
    bus(1, REG_ADDR, {9'h000, a});
    bus(1, REG_WDATA, {16'h0000, d});
    n = 0;
    bus(1, REG_CMD, {28'h000_0000, c});
    do bus(0, REG_STATUS, 0); while (!(rv[3] | rv[2]));
    sv = rv;
    bus(1, REG_STATUS, 32'h0000_000e);
  endtask
  task rdw(input logic [22:0] a);
    op(a, 0, OP_READ);
    bus(0, REG_RDATA, 0);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    bus(0, REG_CTRL, 0);
    chk(rv, 32'h0000_0001);
    bus(0, 12'h3c0, 0);
    chk(rv, 0);
    $display("test reset ended");
    op(23'h01_0010, 16'h3c5a, OP_PROG);
    chk(n, 4);
    rdw(23'h01_0010);
    chk(rv, 32'h0000_3c5a);
    op(23'h02_0000, 0, OP_BYP_ENTER);
    for (int i = 0; i < 8; i++) begin
      op(23'h02_0000 + 23'(i), 16'h1200 + 16'(i), OP_BYP_PROG);
      chk(n, 2);
    end
    op(23'h02_0000, 0, OP_BYP_EXIT);
    op(23'h02_0003, 0, OP_PAGE);
    for (int i = 0; i < 8; i++) begin
      bus(0, REG_PAGE + 12'(4 * i), 0);
      chk(rv, 32'h0000_1200 + i);
    end
    $display("test program ended");
    op(23'h01_0000, 0, OP_ERASE);
    rdw(23'h60_0000);
    chk(rv, 32'h0000_ffff);
    op(23'h01_0000, 0, OP_SUSPEND);
    rdw(23'h02_0005);
    chk(rv, 32'h0000_1205);
    op(23'h01_0000, 0, OP_RESUME);
    op(23'h01_0000, 0, OP_POLL);
    rdw(23'h01_0010);
    chk(rv, 32'h0000_ffff);
    rdw(23'h02_0005);
    chk(rv, 32'h0000_1205);
    op(23'h04_8000, 16'h0011, OP_PROG);
    chk(sv[2], 1);
    rdw(23'h04_8000);
    chk(rv, 32'h0000_ffff);
    $display("test erase ended");
    bus(1, REG_CMD, 32'h0000_000f);
    bus(0, REG_STATUS, 0);
    chk(rv[1], 1);
    for (int j = 0; j < 3; j++) begin
      op(0, 0, codes[j]);
      chk(n, cnt[j]);
    end
    bus(1, REG_CTRL, 0);
    repeat (4) @(posedge hclk);
    chk(fs_n, 0);
    bus(1, REG_CTRL, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    chk(fs_n, 1);
    $display("test modes ended");
    conclude;
  end
endmodule
